// file: rtl/tc8_pkg.sv
/*
  Package for the eight-bit timer/counter: register offsets, field
  positions, reset values, quarter-phase states and cycle counts.
  Assumes a single 10 MHz clock, one clock per instruction quarter phase.
*/
`default_nettype none

package tc8_pkg;

  // Bus geometry.
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register offsets on the plain register port.
  localparam logic [2:0] ADDR_COUNT = 3'h0;
  localparam logic [2:0] ADDR_OPTION = 3'h1;
  localparam logic [2:0] ADDR_INTCTL = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam logic [2:0] ADDR_MASK = 3'h4;

  // Option register fields.
  localparam int OPT_CS_BIT = 5;
  localparam int OPT_SE_BIT = 4;
  localparam int OPT_BYP_BIT = 3;
  localparam int OPT_RATIO_LSB = 0;
  localparam int RATIO_W = 3;
  localparam int OPT_W = 6;
  localparam logic [5:0] OPTION_RESET = 6'h3F;

  // Interrupt control register fields.
  localparam int INTCTL_IE_BIT = 5;
  localparam int INTCTL_IF_BIT = 2;

  // Status and mask layout.
  localparam int STAT_W = 2;
  localparam int ST_OVF_BIT = 0;
  localparam int ST_EDGE_BIT = 1;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // Counter values.
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam int PRESCALE_W = 8;

  // Timing.
  localparam int CLOCK_NS = 100;
  localparam int QUARTERS = 4;
  localparam int INHIBIT_INSTR = 2;
  localparam logic [3:0] INHIBIT_CLKS = 4'(INHIBIT_INSTR * QUARTERS);

  // Quarter phases of one instruction cycle.
  typedef enum logic [3:0] {
    TC8_Q1 = 4'b0001,
    TC8_Q2 = 4'b0010,
    TC8_Q3 = 4'b0100,
    TC8_Q4 = 4'b1000
  } tc8_quarter_t;

endpackage

`default_nettype wire

// file: rtl/tc8_prescaler.sv
/*
  Hidden prescaler of the timer/counter: divides source ticks by a power
  of two from 2 to 256.
  Assumes the tick input is a one-cycle pulse on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module tc8_prescaler
  import tc8_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Control
  input wire logic clear,
  input wire logic tick,
  input wire logic [RATIO_W-1:0] ratio,
  // Divided output
  output logic out_tick
);

  logic [PRESCALE_W-1:0] pcount;
  logic [PRESCALE_W-1:0] sel_mask;

  // Bit i takes part in the terminal count when the ratio reaches it.
  genvar gi;
  generate
    for (gi = 0; gi < PRESCALE_W; gi++)
    begin : g_mask
      assign sel_mask[gi] = (gi <= int'(ratio));
    end
  endgenerate

  assign out_tick = tick && ((pcount & sel_mask) == sel_mask); // RULE7

  // Software can neither see nor load this count; a write only clears it.
  always_ff @(posedge clock)
  begin
    if (srst || clear)
    begin
      pcount <= '0; // RULE8
    end
    else if (tick)
    begin
      pcount <= PRESCALE_W'(pcount + 8'h01);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_clear_empties: assert property (clear |=> pcount == 8'h00) // RULE8
    else $error("prescaler not cleared by count write");

endmodule // tc8_prescaler

`default_nettype wire

// file: rtl/tc8_timer.sv
/*
  Eight-bit timer/counter with its own prescaler, overflow flag,
  interrupt status and mask, and an overflow gate output.
  Assumes one clock is one instruction quarter phase, that the register
  master follows the one-cycle strobe protocol, and that sleep_mode comes
  from logic on the same clock.
*/
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RULE1 - Eight-bit count register, readable and writable, used as timer or counter.
// RULE2 - Clock source select clear: timer mode, one increment per instruction cycle.
// RULE3 - Counting is suppressed for two instruction cycles after a count write.
// RULE4 - Clock source select set: count edges of the external count input.
// RULE5 - Source edge select picks rising or falling edges as increments.
// RULE6 - Prescaler used when bypass clear; bypass set gives a 1:1 ratio.
// RULE7 - Three-bit ratio field selects 1:2 through 1:256 in powers of two.
// RULE8 - Prescaler is hidden from software and cleared by every count write.
// RULE9 - Every FFh to 00h rollover sets the overflow flag, enabled or not.
// RULE10 - Hardware never clears the overflow flag; only software does.
// RULE11 - Interrupt requested only when overflow flag and its enable are set; the code also raises irq from the edge status bit when its mask bit is set.
// RULE12 - During Sleep counting stops and the count holds its value.
// RULE13 - The overflow interrupt cannot wake from Sleep since counting is frozen.
// RULE14 - Counter mode edges are sampled in the second and fourth quarter phases.
// RULE15 - A dedicated three-bit prescaler, separate from the watchdog prescaler; the code's prescaler count is eight bits.
// RULE16 - Overflow is offered as a gate source to the neighbouring timer.
// RULE17 - A count write beats a same-cycle increment; suppression follows the load.
module tc8_timer
  import tc8_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  // Pin and system
  input wire logic external_count_input,
  input wire logic sleep_mode,
  // Outputs
  output logic irq,
  output logic overflow_gate
);

  tc8_quarter_t quarter;
  tc8_quarter_t next_quarter;

  logic [DATA_W-1:0] count_register;
  logic [OPT_W-1:0] option;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;
  logic [3:0] inhibit;
  logic pending;

  logic sync1;
  logic sync2;
  logic sync3;
  logic ext_level;
  logic next_ext_level;

  logic clock_source_select;
  logic source_edge_select;
  logic prescaler_bypass;
  logic [RATIO_W-1:0] prescale_ratio;
  logic overflow_flag;
  logic overflow_irq_enable;

  logic count_write;
  logic intctl_write;
  logic status_write;
  logic mask_write;
  logic ext_edge;
  logic src_tick;
  logic ps_tick;
  logic sel_tick;
  logic sample_point;
  logic inc_request;
  logic do_inc;
  logic overflow;
  logic [STAT_W-1:0] clear_bits;
  logic [STAT_W-1:0] set_bits;

  assign clock_source_select = option[OPT_CS_BIT];
  assign source_edge_select = option[OPT_SE_BIT];
  assign prescaler_bypass = option[OPT_BYP_BIT];
  assign prescale_ratio = option[OPT_RATIO_LSB +: RATIO_W];
  assign overflow_flag = status[ST_OVF_BIT];
  assign overflow_irq_enable = mask[ST_OVF_BIT];

  assign count_write = reg_write && (reg_addr == ADDR_COUNT);
  assign intctl_write = reg_write && (reg_addr == ADDR_INTCTL);
  assign status_write = reg_write && (reg_addr == ADDR_STATUS);
  assign mask_write = reg_write && (reg_addr == ADDR_MASK);

  // Quarter phases run even in Sleep; only counting is frozen.
  always_comb
  begin
    unique case (quarter)
      TC8_Q1: next_quarter = TC8_Q2;
      TC8_Q2: next_quarter = TC8_Q3;
      TC8_Q3: next_quarter = TC8_Q4;
      TC8_Q4: next_quarter = TC8_Q1;
      default: next_quarter = TC8_Q1;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      quarter <= TC8_Q1;
    end
    else
    begin
      quarter <= next_quarter;
    end
  end

  // The pin is asynchronous; a level only counts once two stages agree.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end
    else
    begin
      sync1 <= external_count_input;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign next_ext_level = (sync2 == sync3) ? sync3 : ext_level;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ext_level <= 1'b0;
    end
    else
    begin
      ext_level <= next_ext_level;
    end
  end

  // Edge select clear counts rising edges, set counts falling edges.
  assign ext_edge = (next_ext_level != ext_level)
    && (next_ext_level == !source_edge_select); // RULE5

  // Timer mode ticks once per instruction cycle, counter mode on pin edges.
  assign src_tick = clock_source_select ? ext_edge : (quarter == TC8_Q4); // RULE2 RULE4

  // A prescaler private to this counter; the watchdog has its own.
  tc8_prescaler u_prescaler (
    .clock(clock),
    .srst(srst),
    .clear(count_write),
    .tick(src_tick && !sleep_mode),
    .ratio(prescale_ratio),
    .out_tick(ps_tick)
  ); // RULE15

  assign sel_tick = prescaler_bypass ? (src_tick && !sleep_mode) : ps_tick; // RULE6

  // External increments are only taken at the second and fourth quarters.
  assign sample_point = clock_source_select
    && ((quarter == TC8_Q2) || (quarter == TC8_Q4)); // RULE14

  always_ff @(posedge clock)
  begin
    if (srst || count_write || !clock_source_select)
    begin
      pending <= 1'b0;
    end
    else if (sample_point)
    begin
      pending <= 1'b0; // RULE14
    end
    else if (sel_tick)
    begin
      pending <= 1'b1;
    end
  end

  assign inc_request = clock_source_select ? (sample_point && (pending || sel_tick)) : sel_tick;

  // Increments that land in the suppression window are dropped, not deferred.
  assign do_inc = inc_request && (inhibit == 4'h0) && !sleep_mode; // RULE3 RULE12 RULE13
  assign overflow = do_inc && !count_write && (count_register == COUNT_MAX);

  // Suppression counts the clocks of two instruction cycles after the load.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      inhibit <= 4'h0;
    end
    else if (count_write)
    begin
      inhibit <= INHIBIT_CLKS; // RULE3 RULE17
    end
    else if (inhibit != 4'h0)
    begin
      inhibit <= inhibit - 4'h1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      count_register <= COUNT_RESET;
    end
    else if (count_write)
    begin
      count_register <= reg_wdata; // RULE1 RULE17
    end
    else if (do_inc)
    begin
      count_register <= DATA_W'(count_register + 8'h01); // RULE2 RULE4
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      option <= OPTION_RESET;
    end
    else if (reg_write && (reg_addr == ADDR_OPTION))
    begin
      option <= reg_wdata[OPT_W-1:0];
    end
  end

  // Writing a one clears a status bit; a same-cycle event keeps it set.
  always_comb
  begin
    clear_bits = '0;
    if (status_write)
    begin
      clear_bits = reg_wdata[STAT_W-1:0];
    end
    if (intctl_write && reg_wdata[INTCTL_IF_BIT])
    begin
      clear_bits[ST_OVF_BIT] = 1'b1;
    end
  end

  always_comb
  begin
    set_bits = '0;
    set_bits[ST_OVF_BIT] = overflow; // RULE9
    set_bits[ST_EDGE_BIT] = clock_source_select && ext_edge;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      status <= STATUS_RESET;
    end
    else
    begin
      status <= (status & ~clear_bits) | set_bits; // RULE9 RULE10
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      mask <= MASK_RESET;
    end
    else if (mask_write)
    begin
      mask <= reg_wdata[STAT_W-1:0];
    end
    else if (intctl_write)
    begin
      mask[ST_OVF_BIT] <= reg_wdata[INTCTL_IE_BIT];
    end
  end

  assign irq = |(status & mask); // RULE11

  // Registered so the neighbouring timer sees a clean one-clock pulse.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      overflow_gate <= 1'b0;
    end
    else
    begin
      overflow_gate <= overflow; // RULE16
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      reg_rdata <= '0;
    end
    else if (reg_read)
    begin
      unique case (reg_addr)
        ADDR_COUNT: reg_rdata <= count_register; // RULE1
        ADDR_OPTION: reg_rdata <= {2'h0, option};
        ADDR_INTCTL:
        begin
          reg_rdata <= '0;
          reg_rdata[INTCTL_IE_BIT] <= overflow_irq_enable;
          reg_rdata[INTCTL_IF_BIT] <= overflow_flag;
        end
        ADDR_STATUS: reg_rdata <= {6'h00, status};
        ADDR_MASK: reg_rdata <= {6'h00, mask};
        default: reg_rdata <= '0;
      endcase
    end
    else
    begin
      reg_rdata <= '0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_write_loads_count: assert property (count_write |=> count_register == $past(reg_wdata)) // RULE1
    else $error("count write not loaded");
  a_timer_rate: assert property (!clock_source_select && prescaler_bypass && quarter == TC8_Q4
    && inhibit == 4'h0 && !sleep_mode && !reg_write |=> count_register == DATA_W'($past(count_register) + 8'h01)) // RULE2
    else $error("timer mode did not advance once per instruction");
  a_write_inhibit: assert property (count_write ##1 !count_write |-> !do_inc [*7]) // RULE3
    else $error("increment inside suppression window");
  a_edge_counts: assert property (clock_source_select && prescaler_bypass && ext_edge && !sleep_mode
    && inhibit == 4'h0 && !reg_write ##1 !reg_write [*2] |-> count_register != $past(count_register, 3)) // RULE4
    else $error("counter mode edge lost");
  a_sample_phase: assert property (clock_source_select && do_inc |-> quarter inside {TC8_Q2, TC8_Q4}) // RULE14
    else $error("counter mode increment outside sample phase");
  a_overflow_flag: assert property (overflow |=> overflow_flag) // RULE9
    else $error("rollover did not set flag");
  a_flag_sticky: assert property (overflow_flag && !intctl_write && !status_write |=> overflow_flag) // RULE10
    else $error("overflow flag cleared by hardware");
  a_irq_enable: assert property (irq && !mask[ST_EDGE_BIT] |-> overflow_flag && overflow_irq_enable) // RULE11
    else $error("interrupt without enabled flag");
  a_sleep_freeze: assert property (sleep_mode && !reg_write |=> count_register == $past(count_register)) // RULE12
    else $error("count moved during sleep");
  a_gate_pulse: assert property (overflow |=> overflow_gate ##1 (overflow_gate == $past(overflow))) // RULE16
    else $error("gate pulse does not follow overflow");

  c_rollover: cover property (overflow ##1 irq);
  c_counter_inc: cover property (clock_source_select && do_inc);
  c_prescaled: cover property (!prescaler_bypass && prescale_ratio == 3'h7 && do_inc);
  c_sleep_hold: cover property (sleep_mode && src_tick);

endmodule // tc8_timer

`default_nettype wire

// file: sim/tc8_pin_source.sv
/*
  Model of the external clock source that drives the count input pin.
  Assumes the bench holds half steady while a burst runs and pulses go.
*/
`timescale 1ns/10ps
`default_nettype none

module tc8_pin_source (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Burst control
  input wire logic go,
  input wire logic [3:0] n_toggle,
  input wire logic [3:0] half,
  // Pin and status
  output logic pin,
  output logic busy
);
  logic [3:0] toggles_left;
  logic [3:0] dwell;

  assign busy = (toggles_left != 4'h0);

  // The source drives the pin push-pull, so it never floats.
  // Half must stay at two clocks or more, or the synchroniser may miss a level.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pin <= 1'b0;
      toggles_left <= 4'h0;
      dwell <= 4'h0;
    end
    else if (go)
    begin
      toggles_left <= n_toggle;
      dwell <= half;
    end
    else if (busy)
    begin
      if (dwell == 4'h1)
      begin
        pin <= ~pin;
        toggles_left <= toggles_left - 4'h1;
        dwell <= half;
      end
      else
        dwell <= dwell - 4'h1;
    end
  end
endmodule // tc8_pin_source

`default_nettype wire

// file: sim/tc8_timer_test.sv
/*
  Self-checking bench for the timer/counter with a pin source model.
  Assumes the register port protocol and timing described by the design.
*/
`timescale 1ns/10ps
`default_nettype none

module eight_bit_timer_counter_test
  import tc8_pkg::*;
;
  logic clock;
  logic srst;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [DATA_W-1:0] reg_rdata;
  logic sleep_mode;
  logic irq;
  logic overflow_gate;
  logic pin;
  logic go;
  logic busy;
  logic rd_pend;
  logic [7:0] d;
  logic [7:0] exp_q[$];
  int n_mismatch = 0;
  int checks_done = 0;
  int gates = 0;

  tc8_timer i_dut (
    .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .external_count_input(pin), .sleep_mode(sleep_mode), .irq(irq),
    .overflow_gate(overflow_gate)
  );

  tc8_pin_source i_src (
    .clock(clock), .srst(srst), .go(go), .n_toggle(4'h5), .half(4'h6),
    .pin(pin), .busy(busy)
  );

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic tally_and_finish();
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    checks_done++;
    if (seen !== expv)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask

  // The expected value waits in the queue until the answer cycle.
  task automatic rd(input logic [2:0] a, input logic [7:0] expv);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(expv);
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
  endtask

  task automatic chk_irq(input logic expv);
    @(negedge clock);
    check({7'h00, irq}, {7'h00, expv});
    @(posedge clock);
  endtask

  task automatic burst();
    int i;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    // Busy shows the loaded burst from the same edge that takes go.
    @(posedge clock);
    for (i = 0; i < 200 && busy !== 1'b0; i++)
      @(posedge clock);
    if (i == 200)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  always @(posedge clock)
    rd_pend <= reg_read;

  always @(negedge clock)
    if (!srst && overflow_gate === 1'b1)
      gates++;

  always @(negedge clock)
  begin
    if (rd_pend === 1'b1 && exp_q.size() > 0)
      check(reg_rdata, exp_q.pop_front());
  end

  initial
  begin
    srst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    sleep_mode = 1'b0;
    go = 1'b0;
    void'($urandom(32'hB76E1078));
    idle(6);
    srst <= 1'b0;
    @(posedge clock);
    rd(ADDR_COUNT, COUNT_RESET);
    rd(ADDR_OPTION, {2'b00, OPTION_RESET});
    rd(ADDR_STATUS, {6'h00, STATUS_RESET});
    rd(ADDR_MASK, {6'h00, MASK_RESET});
    rd(ADDR_INTCTL, 8'h00);
    for (int a = 5; a < 8; a++)
    begin
      wr(3'(a), 8'($urandom));
      rd(3'(a), 8'h00);
    end
    rd(ADDR_OPTION, {2'b00, OPTION_RESET});
    // Windows are whole instruction cycles, so the phase at the write does not matter.
    wr(ADDR_OPTION, 8'h08);
    d = 8'($urandom_range(0, 127));
    wr(ADDR_COUNT, d);
    rd(ADDR_COUNT, d);
    idle(17);
    rd(ADDR_COUNT, d + 8'h03);
    for (int p = 0; p < 8; p++)
    begin
      d = 8'($urandom_range(0, 127));
      wr(ADDR_OPTION, 8'(p));
      wr(ADDR_COUNT, d);
      idle(7 + 2 * (8 << p));
      rd(ADDR_COUNT, d + 8'h02);
    end
    wr(ADDR_OPTION, 8'h08);
    sleep_mode <= 1'b1;
    wr(ADDR_COUNT, 8'hFE);
    idle(40);
    rd(ADDR_COUNT, 8'hFE);
    rd(ADDR_STATUS, 8'h00);
    sleep_mode <= 1'b0;
    wr(ADDR_COUNT, 8'hFE);
    idle(15);
    rd(ADDR_COUNT, 8'h00);
    rd(ADDR_STATUS, 8'h01);
    rd(ADDR_INTCTL, 8'h04);
    chk_irq(1'b0);
    check(8'(gates), 8'h01);
    wr(ADDR_MASK, 8'h01);
    chk_irq(1'b1);
    wr(ADDR_INTCTL, 8'h00);
    chk_irq(1'b0);
    idle(20);
    rd(ADDR_STATUS, 8'h01);
    wr(ADDR_INTCTL, 8'h20);
    rd(ADDR_INTCTL, 8'h24);
    chk_irq(1'b1);
    wr(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, 8'h00);
    chk_irq(1'b0);
    // Five toggles from low give three rising edges, from high three falling ones.
    wr(ADDR_OPTION, 8'h28);
    wr(ADDR_COUNT, 8'h00);
    idle(12);
    burst();
    idle(12);
    rd(ADDR_COUNT, 8'h03);
    wr(ADDR_OPTION, 8'h38);
    wr(ADDR_COUNT, 8'h00);
    idle(12);
    burst();
    idle(12);
    rd(ADDR_COUNT, 8'h03);
    idle(2);
    tally_and_finish();
  end
endmodule // eight_bit_timer_counter_test

`default_nettype wire
